// ==== design/adcps_defines.svh ====
// Purpose: constants for the converter power and reference sequencer
// Assumes: 100 MHz system clock, separate link oversampling clock
// Notes:   offsets none; only bus and reset constants live here
`ifndef ADCPS_DEFINES_SVH
`define ADCPS_DEFINES_SVH

// fixed upper address bits, low four come from address straps
`define ADCPS_ADDR_PREFIX  3'h3
// bits per transferred byte, counted from zero
`define ADCPS_LAST_BIT     4'h7
`define ADCPS_ADDR_BITS    4'h8
// result width including trailing sub-bits
`define ADCPS_RES_W        16
// reset values: everything powered down
`define ADCPS_RST_PWR      1'h0
`define ADCPS_RST_TGL      1'h0

`endif

// ==== design/adcps_pkg.sv ====
// Purpose: shared types for the converter power and reference sequencer
// Assumes: constants come from adcps_defines.svh
// Notes:   result struct carries straight binary code plus sub-bits
package adcps_pkg;

  // conversion result as shifted out, msb first
  typedef struct packed {
    logic [13:0] code;
    logic        trailing_sub_bit_high;
    logic        trailing_sub_bit_low;
  } adcps_result_s;

  // link side bus state
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_ADDR = 3'b001,
    L_AACK = 3'b010,
    L_CONV = 3'b011,
    L_TX   = 3'b100,
    L_MACK = 3'b101
  } adcps_link_e;

  // system side converter power state
  typedef enum logic [0:0] {
    S_SHDN = 1'b0,
    S_CONV = 1'b1
  } adcps_sys_e;

endpackage

// ==== design/adcps_top.sv ====
// Purpose: power-up, power-down and reference shutdown control of a
//          14-bit converter read over a two-wire serial bus
// Assumes: clk_link free-running oversampling clock for the bus logic;
//          open-drain pins split into in / oe, output level always low
// Notes:   link and system domains exchange toggles with stable data
`timescale 1ns/100ps
`include "adcps_defines.svh"

module adcps_top
  import adcps_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  input  wire logic          clk_link,
  input  wire logic          scl_in,
  output logic               scl_out,
  output logic               scl_oe,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe,
  input  wire logic [3:0]    addr_pins,
  input  wire logic          reference_adjust_pin,
  output logic               conv_power_en,
  output logic               conv_start,
  input  wire logic          conv_done,
  input  wire adcps_result_s conv_result,
  output logic               ref_power_en,
  output logic               ref_powered,
  output logic               ref_shdn_pending
);

  ////////////////////////////////////////////////////////////////////
  // link domain: pin synchronisers
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;
  logic rdy_s1_r, rdy_s2_r, rdy_d_r;
  logic rdy_tgl_r;
  logic [3:0] addr_s1_r, addr_s2_r;

  // two flops per pin, third copy only for edges
  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      scl_s1_r <= 1'h1;
      scl_s2_r <= 1'h1;
      scl_d_r  <= 1'h1;
      sda_s1_r <= 1'h1;
      sda_s2_r <= 1'h1;
      sda_d_r  <= 1'h1;
      rdy_s1_r <= `ADCPS_RST_TGL;
      rdy_s2_r <= `ADCPS_RST_TGL;
      rdy_d_r  <= `ADCPS_RST_TGL;
      addr_s1_r <= 4'h0;
      addr_s2_r <= 4'h0;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
      rdy_s1_r <= rdy_tgl_r;
      rdy_s2_r <= rdy_s1_r;
      rdy_d_r  <= rdy_s2_r;
      addr_s1_r <= addr_pins;
      addr_s2_r <= addr_s1_r;
    end
  end
  // bus events seen on synchronised pins
  logic scl_rise, scl_fall, bus_start, bus_stop, rdy_evt;
  assign scl_rise  = scl_s2_r & ~scl_d_r;
  assign scl_fall  = ~scl_s2_r & scl_d_r;
  assign bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign bus_stop  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  assign rdy_evt   = rdy_s2_r ^ rdy_d_r;
  ////////////////////////////////////////////////////////////////////
  // link domain: slave state machine
  adcps_link_e   l_st_r;
  logic [3:0]    bitcnt_r;
  logic [7:0]    addr_sh_r;
  logic [15:0]   tx_sh_r;
  logic          byte_r, mack_r, rw_r;
  logic          wake_tgl_r, end_tgl_r;
  logic          sda_oe_r, scl_oe_r;
  adcps_result_s result_r;
  logic          addr_hit;
  assign addr_hit = (addr_sh_r[7:1] == {`ADCPS_ADDR_PREFIX, addr_s2_r});

  // addressing restarts in every state except L_CONV, where start and stop are ignored
  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      l_st_r     <= L_IDLE;
      bitcnt_r   <= 4'h0;
      addr_sh_r  <= 8'h00;
      tx_sh_r    <= 16'h0000;
      byte_r     <= 1'h0;
      mack_r     <= 1'h0;
      rw_r       <= 1'h1;
      wake_tgl_r <= `ADCPS_RST_TGL;
      end_tgl_r  <= `ADCPS_RST_TGL;
      sda_oe_r   <= 1'h0;
      scl_oe_r   <= 1'h0;
    end else if (bus_start && l_st_r != L_CONV) begin
      l_st_r   <= L_ADDR;
      bitcnt_r <= 4'h0;
      sda_oe_r <= 1'h0;
    end else if (bus_stop && l_st_r != L_CONV) begin
      l_st_r   <= L_IDLE;
      sda_oe_r <= 1'h0;
    end else begin
      unique case (l_st_r)
        L_IDLE: sda_oe_r <= 1'h0;
        L_ADDR: begin
          if (scl_rise) begin
            addr_sh_r <= {addr_sh_r[6:0], sda_s2_r};
            bitcnt_r  <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == `ADCPS_ADDR_BITS) begin
            bitcnt_r <= 4'h0;
            if (addr_hit) begin
              l_st_r   <= L_AACK;
              sda_oe_r <= 1'h1;
              rw_r     <= addr_sh_r[0];
            end else begin
              l_st_r <= L_IDLE;
            end
          end
        end
        L_AACK: begin
          // ninth falling edge: wake converter, stretch clock
          if (scl_fall) begin
            sda_oe_r   <= 1'h0;
            scl_oe_r   <= 1'h1;
            wake_tgl_r <= ~wake_tgl_r;
            l_st_r     <= L_CONV;
            byte_r     <= 1'h0;
          end
        end
        L_CONV: begin
          if (rdy_evt) begin
            tx_sh_r  <= result_r;
            sda_oe_r <= ~result_r[15];
            bitcnt_r <= 4'h0;
            l_st_r   <= L_TX;
          end
        end
        L_TX: begin
          // stretch ends a cycle after the first bit is on the line
          scl_oe_r <= 1'h0;
          if (scl_fall) begin
            tx_sh_r  <= {tx_sh_r[14:0], 1'h0};
            bitcnt_r <= bitcnt_r + 4'h1;
            if (bitcnt_r == `ADCPS_LAST_BIT) begin
              sda_oe_r <= 1'h0;
              l_st_r   <= L_MACK;
            end else begin
              sda_oe_r <= ~tx_sh_r[14];
            end
          end
        end
        L_MACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_s2_r;
          end else if (scl_fall) begin
            bitcnt_r <= 4'h0;
            if (!mack_r) begin
              end_tgl_r <= ~end_tgl_r;
              l_st_r    <= L_IDLE;
            end else if (!byte_r) begin
              byte_r   <= 1'h1;
              sda_oe_r <= ~tx_sh_r[15];
              l_st_r   <= L_TX;
            end else begin
              wake_tgl_r <= ~wake_tgl_r;
              scl_oe_r   <= 1'h1;
              byte_r     <= 1'h0;
              l_st_r     <= L_CONV;
            end
          end
        end
        default: l_st_r <= L_IDLE;
      endcase
    end
  end

  assign sda_oe  = sda_oe_r;
  assign scl_oe  = scl_oe_r;
  assign sda_out = 1'h0;
  assign scl_out = 1'h0;
  ////////////////////////////////////////////////////////////////////
  // system domain: event synchronisers
  logic wake_s1_r, wake_s2_r, wake_d_r;
  logic end_s1_r, end_s2_r, end_d_r;
  logic ext_s1_r, ext_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wake_s1_r <= `ADCPS_RST_TGL;
      wake_s2_r <= `ADCPS_RST_TGL;
      wake_d_r  <= `ADCPS_RST_TGL;
      end_s1_r  <= `ADCPS_RST_TGL;
      end_s2_r  <= `ADCPS_RST_TGL;
      end_d_r   <= `ADCPS_RST_TGL;
      ext_s1_r  <= 1'h0;
      ext_r     <= 1'h0;
    end else begin
      wake_s1_r <= wake_tgl_r;
      wake_s2_r <= wake_s1_r;
      wake_d_r  <= wake_s2_r;
      end_s1_r  <= end_tgl_r;
      end_s2_r  <= end_s1_r;
      end_d_r   <= end_s2_r;
      ext_s1_r  <= reference_adjust_pin;
      ext_r     <= ext_s1_r;
    end
  end

  logic wake_evt, end_evt;
  assign wake_evt = wake_s2_r ^ wake_d_r;
  assign end_evt  = end_s2_r ^ end_d_r;
  ////////////////////////////////////////////////////////////////////
  // system domain: converter power, same for either reference
  adcps_sys_e s_st_r;
  logic       conv_pwr_r, conv_start_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_st_r       <= S_SHDN;
      conv_pwr_r   <= `ADCPS_RST_PWR;
      conv_start_r <= 1'h0;
      rdy_tgl_r    <= `ADCPS_RST_TGL;
      result_r     <= '0;
    end else begin
      conv_start_r <= 1'h0;
      unique case (s_st_r)
        S_SHDN: begin
          if (wake_evt) begin
            conv_pwr_r   <= 1'h1;
            conv_start_r <= 1'h1;
            s_st_r       <= S_CONV;
          end
        end
        S_CONV: begin
          if (conv_done) begin
            result_r   <= conv_result;
            rdy_tgl_r  <= ~rdy_tgl_r;
            conv_pwr_r <= 1'h0;
            s_st_r     <= S_SHDN;
          end
        end
      endcase
    end
  end

  assign conv_power_en = conv_pwr_r;
  assign conv_start    = conv_start_r;
  ////////////////////////////////////////////////////////////////////
  // system domain: internal reference power and shutdown arming
  logic ref_pwr_r, pend_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ref_pwr_r <= `ADCPS_RST_PWR;
      pend_r    <= 1'h0;
    end else if (wake_evt) begin
      pend_r <= ~ext_r & ~rw_r;
      if (!ext_r) begin
        ref_pwr_r <= 1'h1;
      end
    end else if (end_evt && pend_r && !ext_r) begin
      ref_pwr_r <= 1'h0;
      pend_r    <= 1'h0;
    end
  end

  // rw_r settles in the link domain before the wake toggle crosses
  assign ref_power_en     = ref_pwr_r & ~ext_r;
  assign ref_powered      = ref_pwr_r;
  assign ref_shdn_pending = pend_r;
  ////////////////////////////////////////////////////////////////////
  // checks
  sequence s_ack_end;
    l_st_r == L_AACK && scl_fall && !bus_start && !bus_stop;
  endsequence
  sequence s_conv_done;
    s_st_r == S_CONV && conv_done;
  endsequence

  a_wake_powers_up: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_st_r == S_SHDN && wake_evt |=> conv_power_en && conv_start ##1 !conv_start)
    else $error("converter not powered on wake");
  a_done_powers_dn: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_conv_done |=> !conv_power_en && rdy_tgl_r != $past(rdy_tgl_r))
    else $error("converter not powered down after conversion");
  a_ext_ignores_rw: assert property (@(posedge clk_sys) disable iff (!rstn)
    ext_r && $past(ext_r) |-> !pend_r || !$past(wake_evt))
    else $error("rw used in external reference mode");
  a_rw_arms_shdn: assert property (@(posedge clk_sys) disable iff (!rstn)
    wake_evt && !ext_r |=> pend_r == !$past(rw_r))
    else $error("shutdown arm does not follow rw");
  a_nack_ref_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    end_evt && !wake_evt && pend_r && !ext_r |=> !ref_power_en && !ref_powered)
    else $error("reference not shut down on not-acknowledge");
  a_wake_ref_on: assert property (@(posedge clk_sys) disable iff (!rstn)
    wake_evt && !ext_r |=> ref_powered ##0 ref_power_en || ext_r)
    else $error("reference not woken on address");
  a_ref_keeps_on: assert property (@(posedge clk_sys) disable iff (!rstn)
    ref_pwr_r && !(end_evt && pend_r) |=> ref_pwr_r)
    else $error("reference dropped without armed shutdown");
  a_ack_to_stretch: assert property (@(posedge clk_link) disable iff (!rstn)
    s_ack_end |=> l_st_r == L_CONV && scl_oe && wake_tgl_r != $past(wake_tgl_r))
    else $error("no stretch or wake after address acknowledge");
  a_stretch_held: assert property (@(posedge clk_link) disable iff (!rstn)
    l_st_r == L_CONV |-> scl_oe && !sda_oe)
    else $error("bus clock not held during conversion");
  a_ack_repeats: assert property (@(posedge clk_link) disable iff (!rstn)
    l_st_r == L_MACK && scl_fall && mack_r && byte_r && !bus_start && !bus_stop
    |=> l_st_r == L_CONV ##1 scl_oe)
    else $error("acknowledge did not start next conversion");

endmodule

// ==== dv/adcps_master.sv ====
// Purpose: two-wire bus master model for the sequencer bench
// Assumes: open-drain lines with pull-ups, resolved in the bench
// Notes:   half period 400 ns; the stretch wait is bounded
`timescale 1ns/100ps

module adcps_master (
  input  wire logic        scl,
  input  wire logic        sda,
  output logic             scl_low,
  output logic             sda_low,
  output logic             got_word,
  output logic [15:0]      word,
  output logic             hang
);
  // lines released at start
  initial begin
    scl_low  = 1'b0;
    sda_low  = 1'b0;
    got_word = 1'b0;
    word     = 16'h0000;
    hang     = 1'b0;
  end

  // one bus clock; waits out a stretch, samples at end of high phase
  task automatic bit_io(input logic b, output logic r);
    int n;
    #100 sda_low = ~b;
    #300 scl_low = 1'b0;
    n = 0;
    // once stuck, later bits skip the wait so the run ends quickly
    while (scl !== 1'b1 && n < 2000 && !hang) begin
      #10 n++;
    end
    if (n == 2000) hang = 1'b1;
    #400 r = sda;
    scl_low = 1'b1;
  endtask

  // start, address byte, n results (last one refused), stop
  task automatic xfer(input logic [7:0] ab, input int n, output logic ack);
    logic r;
    sda_low = 1'b1;
    #400 scl_low = 1'b1;
    for (int i = 7; i >= 0; i--) bit_io(ab[i], r);
    bit_io(1'b1, r);
    ack = ~r;
    for (int k = 0; k < n && ack; k++) begin
      for (int i = 15; i >= 0; i--) begin
        bit_io(1'b1, word[i]);
        if (i == 8) bit_io(1'b0, r);
      end
      bit_io(k == n - 1, r);
      got_word = 1'b1;
      #1 got_word = 1'b0;
    end
    #100 sda_low = 1'b1;
    #400 scl_low = 1'b0;
    #400 sda_low = 1'b0;
    #400;
  endtask
endmodule

// ==== dv/adcps_top_tb.sv ====
// Purpose: self-checking bench of the power and reference sequencer
// Assumes: master model on the bus, converter modelled here
// Notes:   expected results noted in a queue, compared as read
`timescale 1ns/100ps

module adcps_top_tb;
  import adcps_pkg::*;
  logic          clk_sys, clk_link, rstn, ref_adj, conv_done;
  logic [3:0]    addr_pins;
  adcps_result_s conv_result;
  logic          scl_oe, sda_oe, conv_power_en, conv_start, scl_out, sda_out;
  logic          ref_power_en, ref_powered, ref_shdn_pending;
  logic          scl_low, sda_low, got_word, hang, ack;
  logic [15:0]   word;
  logic [31:0]   rnd;
  int            cnt, err_total, n_tests;
  logic [15:0]   exp_q[$];
  // pulled-up lines; the device pulls low only while enabled with a low level
  wire           scl = ~(scl_low | (scl_oe & ~scl_out));
  wire           sda = ~(sda_low | (sda_oe & ~sda_out));
  // per scenario bit i: ext mode, rw bit, extra result, expected flags
  localparam logic [4:0] EXT_T = 5'b11000;
  localparam logic [4:0] RW_T  = 5'b10101;
  localparam logic [4:0] N_T   = 5'b01001;
  localparam logic [4:0] PW_T  = 5'b11101;
  localparam logic [4:0] EN_T  = 5'b00101;

  adcps_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_pins(addr_pins), .reference_adjust_pin(ref_adj),
    .conv_power_en(conv_power_en), .conv_start(conv_start),
    .conv_done(conv_done), .conv_result(conv_result),
    .ref_power_en(ref_power_en), .ref_powered(ref_powered),
    .ref_shdn_pending(ref_shdn_pending));

  adcps_master i_mst (.scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low), .got_word(got_word), .word(word), .hang(hang));

  ////////////////////////////////////////////////////////////////////////
  // clocks, link clock unrelated in phase
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #24 clk_link = ~clk_link;
  end

  // converter: random result and delay per start, noted as expected
  always @(negedge clk_sys) begin
    conv_done <= 1'b0;
    if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) conv_done <= 1'b1;
    end
    if (conv_start === 1'b1) begin
      rnd = $urandom;
      conv_result <= adcps_result_s'(rnd[15:0]);
      exp_q.push_back(rnd[15:0]);
      cnt <= 5 + int'(rnd[20:16]);
    end
  end

  // each word read by the master against the oldest note
  always @(posedge got_word) begin
    if (exp_q.size() == 0) chk_word(word, 16'hxxxx);
    else chk_word(word, exp_q.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // a bus transfer, then the stuck-clock guard
  task automatic run(input logic [7:0] ab, input int n);
    i_mst.xfer(ab, n, ack);
    chk_bit(hang, 1'b0, "bus stuck");
    if (hang) results();
    else repeat (10) @(negedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rstn = 1'b0;
    ref_adj = 1'b0;
    conv_done = 1'b0;
    conv_result = '0;
    cnt = 0;
    err_total = 0;
    n_tests = 0;
    void'($urandom(32'h7532));
    rnd = $urandom;
    addr_pins = rnd[3:0];
    // reset spans two edges of the slower link clock as well
    repeat (2) @(posedge clk_link);
    chk_bit(conv_power_en, 1'b0, "power in reset");
    chk_bit(scl_oe | sda_oe, 1'b0, "bus pins in reset");
    @(negedge clk_sys) rstn = 1'b1;
    repeat (10) @(posedge clk_link);
    @(negedge clk_sys);
    chk_bit(ref_powered, 1'b0, "ref after reset");
    // foreign address: no ack, nothing wakes
    run({3'h3, ~addr_pins, 1'b1}, 1);
    chk_bit(ack, 1'b0, "foreign ack");
    chk_bit(ref_powered, 1'b0, "foreign wake");
    $display("test foreign address done");
    for (int i = 0; i < 5; i++) begin
      ref_adj = EXT_T[i];
      repeat (4) @(negedge clk_sys);
      run({3'h3, addr_pins, RW_T[i]}, 1 + int'(N_T[i]));
      chk_bit(ack, 1'b1, "own ack");
      chk_bit(conv_power_en, 1'b0, "power after");
      chk_bit(ref_powered, PW_T[i], "ref flag");
      chk_bit(ref_shdn_pending, 1'b0, "pending");
      chk_bit(ref_power_en, EN_T[i], "ref enable");
      $display("test scenario %0d done", i);
    end
    chk_bit(exp_q.size() == 0, 1'b1, "results left");
    results();
  end
endmodule
